// *** hdl/sse_defs.svh ***
// Purpose: constants for the sleep and subtract execution block
// Assumes: 14-bit instruction words, 8-bit data
// Notes: definitions only
`ifndef SSE_DEFS_SVH
`define SSE_DEFS_SVH
`define SSE_SLEEP_CODE 14'h0063
`define SSE_SUBL_TOP 5'h1E
`define SSE_SUBF_TOP 6'h02
`define SSE_RLF_TOP 6'h0D
`define SSE_RRF_TOP 6'h0C
`define SSE_DEST_BIT 7
`define SSE_W_RESET 8'h00
`define SSE_WDT_CLEAR 8'h00
`define SSE_PRE_CLEAR 8'h00
`endif

// *** hdl/sse_pkg.sv ***
// Purpose: types for the sleep and subtract execution block
// Assumes: one instruction cycle is four phases
// Notes: phase codes are one-hot
package sse_pkg;
    typedef enum logic [3:0]
    {
        SSE_Q1 = 4'h1,
        SSE_Q2 = 4'h2,
        SSE_Q3 = 4'h4,
        SSE_Q4 = 4'h8
    } sse_phase_type;
    typedef enum logic [2:0]
    {
        SSE_OP_NONE = 3'h0,
        SSE_OP_SLEEP = 3'h1,
        SSE_OP_SUBL = 3'h2,
        SSE_OP_SUBF = 3'h3,
        SSE_OP_RLF = 3'h4,
        SSE_OP_RRF = 3'h5
    } sse_op_type;
endpackage : sse_pkg

// *** hdl/sse_alu_if.sv ***
// Purpose: carrier between sequencer and arithmetic unit
// Assumes: combinational unit
// Notes: none
`timescale 1ns/10ps
interface sse_alu_if;
    import sse_pkg::*;
    sse_op_type op; // operation
    logic [7:0] a; // minuend or rotated operand
    logic [7:0] w; // working register
    logic c_in; // carry in
    logic [7:0] res; // result
    logic c_out; // carry out
    logic dc_out; // digit carry out
    logic z_out; // zero out
    modport seq (output op, output a, output w, output c_in,
                 input res, input c_out, input dc_out, input z_out);
    modport alu (input op, input a, input w, input c_in,
                 output res, output c_out, output dc_out, output z_out);
endinterface : sse_alu_if

// *** hdl/sse_alu.sv ***
// Purpose: subtract and rotate arithmetic
// Assumes: pure combinational
// Notes: subtract carry means no borrow
`timescale 1ns/10ps
module sse_alu
(
    // link to sequencer
    sse_alu_if.alu bus
);
    import sse_pkg::*;

    // nine-bit difference, top bit is the no-borrow flag
    function automatic logic [8:0] sse_sub(input logic [7:0] x, input logic [7:0] y);
        sse_sub = {1'b0, x} + {1'b0, ~y} + 9'h001;
    endfunction : sse_sub

    logic [8:0] diff; // full difference
    logic [4:0] ldiff; // low nibble difference

    // arithmetic
    always_comb
    begin
        diff = sse_sub(bus.a, bus.w);
        ldiff = {1'b0, bus.a[3:0]} + {1'b0, ~bus.w[3:0]} + 5'h01;
        bus.res = diff[7:0];
        bus.c_out = diff[8];
        bus.dc_out = ldiff[4];
        if (bus.op == SSE_OP_RLF)
        begin
            bus.res = {bus.a[6:0], bus.c_in};
            bus.c_out = bus.a[7];
        end
        else if (bus.op == SSE_OP_RRF)
        begin
            bus.res = {bus.c_in, bus.a[7:1]};
            bus.c_out = bus.a[0];
        end
        bus.z_out = (bus.res == 8'h00);
    end
endmodule : sse_alu

// *** hdl/sse_exec.sv ***
// Purpose: executes power-down, subtracts and rotates through carry
// Assumes: instruction stable from Q1 through Q4; file data valid by Q2
// Notes: phases run Q1..Q4 continuously while awake
`timescale 1ns/10ps
`include "sse_defs.svh"

// Overview of operation
// - fixed code 0x0063 is the power-down instruction
// - power-down clears watchdog count
// - power-down clears power-down flag, sets time-out
// - power-down halts oscillator, core sleeps
// - power-down: decode, two idle phases, sleep
// - literal subtract writes literal minus W
// - literal subtract matched by top bits 11110x
// - literal subtract updates carry, digit carry, zero
// - carry means no borrow; negative wraps
// - zero flag set when result is zero
// - literal subtract writes W in phase four
// - rotate left through carry, d picks destination
module sse_exec
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // instruction and file operand
    input wire logic [13:0] instr,
    input wire logic [7:0] file_rd_data,
    // wake request from outside, a pin
    input wire logic wake,
    // phase and status
    output sse_pkg::sse_phase_type phase,
    output logic [7:0] w_out,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag,
    output logic power_down_flag_n,
    output logic time_out_flag_n,
    output logic osc_halt,
    // watchdog clears
    output logic [7:0] watchdog_counter_clr_val,
    output logic watchdog_clear,
    // file write port
    output logic file_wr_en,
    output logic [6:0] file_wr_addr,
    output logic [7:0] file_wr_data
);
    import sse_pkg::*;

    // all state
    typedef struct packed
    {
        sse_phase_type phase;
        sse_op_type op;
        logic [7:0] w;
        logic c;
        logic dc;
        logic z;
        logic pd_n;
        logic to_n;
        logic halt;
        logic wdt_clr;
        logic wr_en;
        logic [6:0] wr_addr;
        logic [7:0] wr_data;
        logic [7:0] opnd;
        logic wake_s1;
        logic wake_s2;
    } sse_state_type;

    sse_state_type st_reg; // registered state
    sse_state_type st_next; // next state
    sse_alu_if alu_bus(); // arithmetic link

    // decode opcode from instruction word
    function automatic sse_op_type sse_decode(input logic [13:0] iw);
        if (iw == `SSE_SLEEP_CODE)
            sse_decode = SSE_OP_SLEEP;
        else if (iw[13:9] == `SSE_SUBL_TOP)
            sse_decode = SSE_OP_SUBL;
        else if (iw[13:8] == `SSE_SUBF_TOP)
            sse_decode = SSE_OP_SUBF;
        else if (iw[13:8] == `SSE_RLF_TOP)
            sse_decode = SSE_OP_RLF;
        else if (iw[13:8] == `SSE_RRF_TOP)
            sse_decode = SSE_OP_RRF;
        else
            sse_decode = SSE_OP_NONE;
    endfunction : sse_decode

    // arithmetic unit
    sse_alu u_alu
    (
        .bus(alu_bus)
    );

    // operands to arithmetic
    always_comb
    begin
        alu_bus.op = st_reg.op;
        alu_bus.a = st_reg.opnd;
        alu_bus.w = st_reg.w;
        alu_bus.c_in = st_reg.c;
    end

    // next state
    always_comb
    begin
        st_next = st_reg;
        st_next.wake_s1 = wake;
        st_next.wake_s2 = st_reg.wake_s1;
        st_next.wdt_clr = 1'b0;
        st_next.wr_en = 1'b0;
        if (st_reg.halt)
        begin
            // sleeping: oscillator stopped until wake
            if (st_reg.wake_s2)
            begin
                st_next.halt = 1'b0;
                st_next.phase = SSE_Q1;
            end
        end
        else
        begin
            case (st_reg.phase)
                SSE_Q1:
                begin
                    // decode
                    st_next.op = sse_decode(instr);
                    st_next.phase = SSE_Q2;
                end
                SSE_Q2:
                begin
                    // read operand, literal or file
                    if (st_reg.op == SSE_OP_SUBL)
                        st_next.opnd = instr[7:0];
                    else
                        st_next.opnd = file_rd_data;
                    st_next.phase = SSE_Q3;
                end
                SSE_Q3:
                begin
                    // process data, no action for power-down
                    st_next.phase = SSE_Q4;
                end
                SSE_Q4:
                begin
                    st_next.phase = SSE_Q1;
                    case (st_reg.op)
                        SSE_OP_SLEEP:
                        begin
                            st_next.wdt_clr = 1'b1;
                            st_next.pd_n = 1'b0;
                            st_next.to_n = 1'b1;
                            st_next.halt = 1'b1;
                        end
                        SSE_OP_SUBL, SSE_OP_SUBF:
                        begin
                            st_next.c = alu_bus.c_out;
                            st_next.dc = alu_bus.dc_out;
                            st_next.z = alu_bus.z_out;
                            if (st_reg.op == SSE_OP_SUBF && instr[`SSE_DEST_BIT])
                            begin
                                st_next.wr_en = 1'b1;
                                st_next.wr_addr = instr[6:0];
                                st_next.wr_data = alu_bus.res;
                            end
                            else
                                st_next.w = alu_bus.res;
                        end
                        SSE_OP_RLF, SSE_OP_RRF:
                        begin
                            st_next.c = alu_bus.c_out;
                            if (instr[`SSE_DEST_BIT])
                            begin
                                st_next.wr_en = 1'b1;
                                st_next.wr_addr = instr[6:0];
                                st_next.wr_data = alu_bus.res;
                            end
                            else
                                st_next.w = alu_bus.res;
                        end
                        default:
                        begin
                            // other instructions handled elsewhere
                        end
                    endcase
                end
                default:
                    st_next.phase = SSE_Q1;
            endcase
        end
    end

    // state register with synchronous reset
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_reg <= '0;
            st_reg.phase <= SSE_Q1;
            st_reg.op <= SSE_OP_NONE;
            st_reg.w <= `SSE_W_RESET;
            st_reg.pd_n <= 1'b1;
            st_reg.to_n <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // outputs straight from state, except the constant watchdog clear value
    assign phase = st_reg.phase;
    assign w_out = st_reg.w;
    assign carry_flag = st_reg.c;
    assign digit_carry_flag = st_reg.dc;
    assign zero_flag = st_reg.z;
    assign power_down_flag_n = st_reg.pd_n;
    assign time_out_flag_n = st_reg.to_n;
    assign osc_halt = st_reg.halt;
    assign watchdog_counter_clr_val = `SSE_WDT_CLEAR;
    assign watchdog_clear = st_reg.wdt_clr;
    assign file_wr_en = st_reg.wr_en;
    assign file_wr_addr = st_reg.wr_addr;
    assign file_wr_data = st_reg.wr_data;

    // power-down sets flags and halts after Q4
    sleep_entry_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_reg.phase == SSE_Q4 && st_reg.op == SSE_OP_SLEEP && !st_reg.halt)
        |=> (!power_down_flag_n && time_out_flag_n && osc_halt && watchdog_clear))
        else $error("power-down entry wrong");
    // watchdog clear only on power-down
    wdt_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        watchdog_clear |-> $past(st_reg.op) == SSE_OP_SLEEP && osc_halt)
        else $error("stray watchdog clear");
    // literal subtract result in W
    subl_result_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_reg.phase == SSE_Q4 && st_reg.op == SSE_OP_SUBL)
        |=> w_out == 8'(st_reg.opnd - $past(st_reg.w)))
        else $error("literal subtract result wrong");
    // carry is no borrow
    sub_carry_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_reg.phase == SSE_Q4 && (st_reg.op == SSE_OP_SUBL || st_reg.op == SSE_OP_SUBF))
        |=> carry_flag == ($past(st_reg.opnd) >= $past(st_reg.w)))
        else $error("subtract carry wrong");
    // digit carry is no nibble borrow
    sub_dc_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_reg.phase == SSE_Q4 && st_reg.op == SSE_OP_SUBL)
        |=> digit_carry_flag == ($past(st_reg.opnd[3:0]) >= $past(st_reg.w[3:0])))
        else $error("digit carry wrong");
    // zero flag matches W after literal subtract
    sub_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_reg.phase == SSE_Q4 && st_reg.op == SSE_OP_SUBL)
        |=> zero_flag == (w_out == 8'h00))
        else $error("zero flag wrong");
    // phases rotate Q1 to Q4 while awake
    phase_seq_a: assert property (@(posedge clk) disable iff (!nrst)
        (phase == SSE_Q1 && !osc_halt) |=> phase == SSE_Q2 ##1 phase == SSE_Q3
        ##1 phase == SSE_Q4)
        else $error("phase order wrong");
    // file write only when d was set at the Q4 edge; instr may move on after it
    file_wr_a: assert property (@(posedge clk) disable iff (!nrst)
        file_wr_en |-> phase == SSE_Q1 && $past(phase) == SSE_Q4
        && $past(instr[`SSE_DEST_BIT]))
        else $error("file write misplaced");
    // rotate left carry from bit 7
    rlf_carry_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_reg.phase == SSE_Q4 && st_reg.op == SSE_OP_RLF)
        |=> carry_flag == $past(st_reg.opnd[7]))
        else $error("rotate carry wrong");
endmodule : sse_exec

// *** tb/sleep_and_subtract_exec_tb.sv ***
// Purpose: self-checking bench for the sleep and subtract execution block
// Assumes: one instruction issued each time phase reaches Q4
// Notes: the bench drives every input port itself
`timescale 1ns/10ps
module sleep_and_subtract_exec_tb;
    import sse_pkg::*;
    // stimulus
    logic clk, nrst, wake;
    logic [13:0] instr;
    logic [7:0] file_rd_data;
    // observed
    sse_phase_type phase;
    logic [7:0] w_out, watchdog_counter_clr_val, file_wr_data;
    logic carry_flag, digit_carry_flag, zero_flag, power_down_flag_n;
    logic time_out_flag_n, osc_halt, watchdog_clear, file_wr_en;
    logic [6:0] file_wr_addr;
    // counters and model state
    int fails, checks;
    logic [7:0] w_m; // expected working register
    logic c_m; // expected carry
    sse_exec DUT (.clk(clk), .nrst(nrst), .instr(instr), .file_rd_data(file_rd_data),
        .wake(wake), .phase(phase), .w_out(w_out), .carry_flag(carry_flag),
        .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
        .power_down_flag_n(power_down_flag_n), .time_out_flag_n(time_out_flag_n),
        .osc_halt(osc_halt), .watchdog_counter_clr_val(watchdog_counter_clr_val),
        .watchdog_clear(watchdog_clear), .file_wr_en(file_wr_en),
        .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data));
    // compare one value, count and report
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk
    // subtract reference: {carry, digit carry, zero, result}
    function automatic logic [10:0] sub_ref(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] d;
        logic [4:0] l;
        d = {1'b0, a} - {1'b0, b};
        l = {1'b0, a[3:0]} - {1'b0, b[3:0]};
        return {~d[8], ~l[4], d[7:0] == 8'h00, d[7:0]};
    endfunction : sub_ref
    // flag triple against the reference
    task automatic chk_flags(input logic [10:0] e);
        chk(carry_flag, e[10], "carry");
        chk(digit_carry_flag, e[9], "digit carry");
        chk(zero_flag, e[8], "zero");
    endtask : chk_flags
    // issue one word at the Q4 edge, return just after its write edge
    task automatic exec(input logic [13:0] i, input logic [7:0] f);
        int n = 0;
        @(posedge clk);
        while (phase !== SSE_Q4 && n < 8)
        begin
            n++;
            @(posedge clk);
        end
        instr <= i;
        file_rd_data <= f;
        repeat (4) @(posedge clk);
        instr <= 14'h0000; // unknown code, so nothing repeats
        #1;
    endtask : exec
    // load W through a literal subtract
    task automatic set_w(input logic [7:0] v);
        logic [10:0] e;
        e = sub_ref(v + w_m, w_m);
        exec({5'h1E, 1'b0, v + w_m}, 8'h00);
        w_m = v;
        c_m = e[10];
    endtask : set_w
    // literal subtract over a table, both values of the ignored bit
    task automatic t_literal_subtract_instr();
        logic [7:0] ks [10] = '{8'h01, 8'h02, 8'h03, 8'h02, 8'h03, 8'h02, 8'h0F, 8'h10,
            8'h80, 8'hFF};
        logic [10:0] e;
        foreach (ks[j])
        begin
            e = sub_ref(ks[j], w_m);
            exec({5'h1E, j[0], ks[j]}, 8'h5A);
            w_m = e[7:0];
            chk(w_out, w_m, "literal subtract");
            chk_flags(e);
            c_m = e[10];
        end
    endtask : t_literal_subtract_instr
    // file subtract to file, then to W
    task automatic t_file_subtract_instr();
        logic [7:0] fs [3] = '{8'h03, 8'h02, 8'h01};
        logic [10:0] e;
        set_w(8'h02);
        foreach (fs[j])
        begin
            e = sub_ref(fs[j], w_m);
            exec({6'h02, 1'b1, 7'h05}, fs[j]);
            chk(file_wr_en, 1'b1, "file strobe");
            chk(file_wr_addr, 7'h05, "file address");
            chk(file_wr_data, e[7:0], "file result");
            chk(w_out, w_m, "W kept");
            chk_flags(e);
            @(posedge clk);
            #1;
            chk(file_wr_en, 1'b0, "strobe one cycle");
        end
        e = sub_ref(8'h40, w_m);
        exec({6'h02, 1'b0, 7'h7F}, 8'h40);
        w_m = e[7:0];
        c_m = e[10];
        chk(file_wr_en, 1'b0, "no file write");
        chk(w_out, w_m, "W result");
        chk_flags(e);
    endtask : t_file_subtract_instr
    // rotate left into W, rotate right into the file
    task automatic t_rot();
        logic [7:0] f = 8'hE6;
        logic [7:0] exp;
        exp = {f[6:0], c_m};
        exec({6'h0D, 1'b0, 7'h01}, f);
        chk(w_out, exp, "rotate left");
        chk(carry_flag, f[7], "rotate left carry");
        w_m = exp;
        exp = {f[7], f[7:1]};
        exec({6'h0C, 1'b1, 7'h22}, f);
        chk(file_wr_data, exp, "rotate right");
        chk(carry_flag, f[0], "rotate right carry");
        chk(w_out, w_m, "W kept by rotate");
    endtask : t_rot
    // power-down: a near code, then the real one, halt and wake
    task automatic t_sleep();
        logic [10:0] e;
        int n = 0;
        exec(14'h0062, 8'h00);
        chk(osc_halt, 1'b0, "near code ignored");
        e = sub_ref(w_m, w_m);
        exec({5'h1E, 1'b1, w_m}, 8'h00);
        w_m = 8'h00;
        exec(14'h0063, 8'h00);
        chk(osc_halt, 1'b1, "halt in phase four");
        chk(power_down_flag_n, 1'b0, "power-down flag");
        chk(time_out_flag_n, 1'b1, "time-out flag");
        chk(watchdog_clear, 1'b1, "watchdog clear");
        chk(watchdog_counter_clr_val, 8'h00, "watchdog value");
        chk_flags(e);
        @(posedge clk);
        instr <= {5'h1E, 1'b0, 8'h33}; // must be ignored while asleep
        repeat (7) @(posedge clk);
        #1;
        chk(watchdog_clear, 1'b0, "clear is one pulse");
        chk(osc_halt, 1'b1, "still asleep");
        chk(w_out, w_m, "no work asleep");
        @(posedge clk);
        wake <= 1'b1;
        instr <= 14'h0000;
        while (osc_halt !== 1'b0 && n < 8)
        begin
            n++;
            @(posedge clk);
        end
        wake <= 1'b0;
        chk(osc_halt, 1'b0, "woken");
        exec(14'h0000, 8'h00);
        chk(w_out, w_m, "W kept over sleep");
    endtask : t_sleep
    // verdict and end of run
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    // clock, 10 ns
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // main sequence
    initial
    begin
        nrst = 1'b0;
        wake = 1'b0;
        instr = 14'h0000;
        file_rd_data = 8'h00;
        fails = 0;
        checks = 0;
        w_m = 8'h00;
        c_m = 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk(phase, SSE_Q1, "reset phase");
        chk(w_out, 8'h00, "reset W");
        chk(power_down_flag_n, 1'b1, "reset power-down flag");
        chk(osc_halt, 1'b0, "reset halt");
        t_literal_subtract_instr();
        t_file_subtract_instr();
        t_rot();
        t_sleep();
        end_sim();
    end
    // hang guard, about twice the expected run of some 190 cycles
    initial
    begin
        #4000;
        fails++;
        $display("wrong value at %0t: run did not finish", $time);
        end_sim();
    end
endmodule : sleep_and_subtract_exec_tb
